// [ahb_slave_model.sv]
`timescale 1ns/1ps
module ahb_slave_model (
	// bus side
	input wire logic sys_clk,
	input wire logic reset,
	input xbar_pkg::ahb_req_s req,
	output xbar_pkg::ahb_rsp_s rsp,
	// test control
	input wire logic [1:0] waits,
	output logic [31:0] wdata
);
	logic busy, wr;
	logic [1:0] cnt;
	logic [31:0] addr;
	wire done = busy && cnt == 2'h0;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			busy <= 1'b0;
			wr <= 1'b0;
			cnt <= 2'h0;
			addr <= 32'h0;
			wdata <= 32'h0;
		end else if (!busy && req.htrans[1]) begin
			busy <= 1'b1;
			wr <= req.hwrite;
			addr <= req.haddr;
			cnt <= waits;
		end else if (done) begin
			busy <= 1'b0;
			if (wr) wdata <= req.hwdata;
		end else if (busy) begin
			cnt <= cnt - 2'h1;
		end
	end
	// read data is the inverted address; outside the data phase it shows something else
	assign rsp.hrdata = (done && !wr) ? ~addr : addr;
	assign rsp.hready = !busy || done;
	assign rsp.hresp = 1'b0;
endmodule

// [multilayer_ahb_crossbar.sv]
`timescale 1ns/1ps
module multilayer_ahb_crossbar (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// master ports
	input xbar_pkg::ahb_req_s mst_req [xbar_pkg::N_MST],
	output xbar_pkg::ahb_rsp_s mst_rsp [xbar_pkg::N_MST],
	// slave ports
	output xbar_pkg::ahb_req_s slv_req [xbar_pkg::N_SLV],
	input xbar_pkg::ahb_rsp_s slv_rsp [xbar_pkg::N_SLV],
	// arbitration setup
	input xbar_pkg::arb_mode_e arb_mode [xbar_pkg::N_SLV],
	input wire logic [2:0] park_mst [xbar_pkg::N_SLV],
	input wire logic [2:0] mst_prio [xbar_pkg::N_MST],
	input wire logic [2:0] cc_prio_in,
	input wire logic cc_prio_load,
	// clock controller handshake
	input wire logic clock_ctrl_bus_request,
	output logic clock_ctrl_bus_grant
);
	xbar_pkg::mst_state_e mst_st [xbar_pkg::N_MST];
	xbar_pkg::ahb_req_s cap [xbar_pkg::N_MST];
	logic [1:0] sel [xbar_pkg::N_MST];
	logic [xbar_pkg::N_MST-1:0] mst_done;
	xbar_pkg::slv_state_e slv_st [xbar_pkg::N_SLV];
	logic [2:0] owner [xbar_pkg::N_SLV];
	logic [2:0] rr_last [xbar_pkg::N_SLV];
	logic [xbar_pkg::N_SLV-1:0] cc_hold;
	logic [xbar_pkg::N_SLV-1:0] slv_done;
	logic [xbar_pkg::N_MST-1:0] mreq [xbar_pkg::N_SLV];
	logic [2:0] cc_prio;

	// returns {found, index, rank}; lower rank wins in fixed and programmable modes
	function automatic logic [6:0] arb_pick(input logic [5:0] req, input xbar_pkg::arb_mode_e mode,
			input logic [2:0] lvl [xbar_pkg::N_MST], input logic [2:0] last, input logic [2:0] park);
		logic found;
		logic [2:0] idx;
		logic [2:0] best;
		int c;
		found = 1'b0;
		idx = 3'h0;
		best = 3'h7;
		for (int k = 0; k < xbar_pkg::N_MST; k++) begin
			c = (mode == xbar_pkg::ARB_RR) ? (int'(last) + 1 + k) % xbar_pkg::N_MST : k;
			if (req[c] && (!found || (mode == xbar_pkg::ARB_PROG && lvl[c] < best))) begin
				found = 1'b1;
				idx = 3'(c);
				best = lvl[c];
			end
		end
		if (mode == xbar_pkg::ARB_PARK && park < 3'(xbar_pkg::N_MST) && req[park]) begin
			found = 1'b1;
			idx = park;
		end
		return {found, idx, (mode == xbar_pkg::ARB_PROG) ? best : idx};
	endfunction

	always_ff @(posedge sys_clk) begin
		if (reset)
			cc_prio <= xbar_pkg::CC_PRIO_RST;
		else if (cc_prio_load)
			cc_prio <= cc_prio_in;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			clock_ctrl_bus_grant <= 1'b0;
		else
			clock_ctrl_bus_grant <= clock_ctrl_bus_request && (&cc_hold);
	end

	generate
		for (genvar m = 0; m < xbar_pkg::N_MST; m++) begin : g_mst
			wire sel_ok = (sel[m] != xbar_pkg::SEL_NONE);
			wire accept = (mst_st[m] == xbar_pkg::M_IDLE) && mst_req[m].htrans[1];
			assign mst_done[m] = sel_ok && slv_done[sel[m]] && (owner[sel[m]] == 3'(m));

			always_ff @(posedge sys_clk) begin
				if (reset) begin
					mst_st[m] <= xbar_pkg::M_IDLE;
					mst_rsp[m] <= '{hrdata: 32'h0000_0000, hready: 1'b1, hresp: 1'b0};
					cap[m] <= '0;
					sel[m] <= 2'h0;
				end else begin
					unique case (mst_st[m])
						xbar_pkg::M_IDLE: begin
							mst_rsp[m].hresp <= 1'b0;
							if (accept) begin
								cap[m] <= mst_req[m];
								sel[m] <= mst_req[m].haddr[xbar_pkg::SEL_MSB:xbar_pkg::SEL_LSB];
								mst_rsp[m].hready <= 1'b0;
								mst_st[m] <= xbar_pkg::M_WDAT;
							end
						end
						xbar_pkg::M_WDAT: begin
							cap[m].hwdata <= mst_req[m].hwdata;
							if (!sel_ok) begin
								mst_rsp[m].hresp <= 1'b1;
								mst_st[m] <= xbar_pkg::M_ERR;
							end else begin
								mst_st[m] <= xbar_pkg::M_WAIT;
							end
						end
						xbar_pkg::M_WAIT: begin
							if (mst_done[m]) begin
								mst_rsp[m].hrdata <= slv_rsp[sel[m]].hrdata;
								if (slv_rsp[sel[m]].hresp) begin
									mst_rsp[m].hresp <= 1'b1;
									mst_st[m] <= xbar_pkg::M_ERR;
								end else begin
									mst_rsp[m].hready <= 1'b1;
									mst_st[m] <= xbar_pkg::M_IDLE;
								end
							end
						end
						xbar_pkg::M_ERR: begin
							mst_rsp[m].hready <= 1'b1;
							mst_st[m] <= xbar_pkg::M_IDLE;
						end
					endcase
				end
			end

			a_loser_stalls: assert property (@(posedge sys_clk) disable iff (reset)
				mst_st[m] == xbar_pkg::M_WAIT |-> !mst_rsp[m].hready)
				else $error("waiting master sees hready high");
			a_decode_reach: assert property (@(posedge sys_clk) disable iff (reset)
				(mst_st[m] == xbar_pkg::M_WDAT && sel_ok) |=> mst_st[m] == xbar_pkg::M_WAIT)
				else $error("decoded transfer not queued for its slave");
		end

		for (genvar s = 0; s < xbar_pkg::N_SLV; s++) begin : g_slv
			for (genvar m = 0; m < xbar_pkg::N_MST; m++) begin : g_req
				assign mreq[s][m] = (mst_st[m] == xbar_pkg::M_WAIT) && (sel[m] == 2'(s));
			end
			wire [6:0] pick = arb_pick(mreq[s], arb_mode[s], mst_prio, rr_last[s], park_mst[s]);
			wire found = pick[6];
			wire [2:0] win = pick[5:3];
			wire [2:0] rank = pick[2:0];
			wire cc_wins = clock_ctrl_bus_request && (!found || cc_prio <= rank);
			wire arb_now = (slv_st[s] == xbar_pkg::S_IDLE) && !cc_hold[s];
			assign slv_done[s] = (slv_st[s] == xbar_pkg::S_DATA) && slv_rsp[s].hready;

			always_ff @(posedge sys_clk) begin
				if (reset) begin
					slv_st[s] <= xbar_pkg::S_IDLE;
					owner[s] <= 3'h0;
					rr_last[s] <= xbar_pkg::RR_LAST_RST;
					cc_hold[s] <= 1'b0;
					slv_req[s] <= '0;
				end else begin
					unique case (slv_st[s])
						xbar_pkg::S_IDLE: begin
							if (cc_hold[s]) begin
								cc_hold[s] <= clock_ctrl_bus_request;
							end else if (cc_wins) begin
								cc_hold[s] <= 1'b1;
							end else if (found) begin
								owner[s] <= win;
								rr_last[s] <= win;
								slv_req[s] <= cap[win];
								slv_req[s].htrans <= xbar_pkg::HTRANS_NONSEQ;
								slv_req[s].hburst <= xbar_pkg::HBURST_SINGLE;
								slv_st[s] <= xbar_pkg::S_ADDR;
							end
						end
						xbar_pkg::S_ADDR: begin
							if (slv_rsp[s].hready) begin
								slv_req[s].htrans <= xbar_pkg::HTRANS_IDLE;
								slv_st[s] <= xbar_pkg::S_DATA;
							end
						end
						xbar_pkg::S_DATA: begin
							if (slv_rsp[s].hready)
								slv_st[s] <= xbar_pkg::S_IDLE;
						end
					endcase
				end
			end

			a_slave_no_own: assert property (@(posedge sys_clk) disable iff (reset)
				slv_req[s].htrans != xbar_pkg::HTRANS_IDLE |-> slv_st[s] == xbar_pkg::S_ADDR)
				else $error("slave port drives a transfer with no owner");
			a_port_concurrent: assert property (@(posedge sys_clk) disable iff (reset)
				(arb_now && !clock_ctrl_bus_request && mreq[s] != 6'h00)
				|=> slv_st[s] == xbar_pkg::S_ADDR)
				else $error("free port did not serve its requester");
			a_fixed_winner: assert property (@(posedge sys_clk) disable iff (reset)
				(arb_now && !clock_ctrl_bus_request && arb_mode[s] == xbar_pkg::ARB_FIXED
				&& mreq[s] != 6'h00)
				|=> ($past(mreq[s]) & ((6'h01 << owner[s]) - 6'h01)) == 6'h00)
				else $error("lower priority master granted");
			a_park_winner: assert property (@(posedge sys_clk) disable iff (reset)
				(arb_now && !clock_ctrl_bus_request && arb_mode[s] == xbar_pkg::ARB_PARK
				&& park_mst[s] < 3'h6 && mreq[s][park_mst[s]])
				|=> owner[s] == $past(park_mst[s]))
				else $error("parked master not preferred");
			a_hold_exclusive: assert property (@(posedge sys_clk) disable iff (reset)
				(cc_hold[s] && clock_ctrl_bus_request) |=> cc_hold[s] && slv_st[s] == xbar_pkg::S_IDLE)
				else $error("held port given away");
		end
	endgenerate

	a_grant_needs_hold: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(clock_ctrl_bus_grant) |-> $past(&cc_hold) && $past(clock_ctrl_bus_request))
		else $error("grant raised without every port held");
	a_grant_quiet: assert property (@(posedge sys_clk) disable iff (reset)
		clock_ctrl_bus_grant |-> (slv_req[0].htrans == xbar_pkg::HTRANS_IDLE
		&& slv_req[1].htrans == xbar_pkg::HTRANS_IDLE && slv_req[2].htrans == xbar_pkg::HTRANS_IDLE
		&& slv_done == 3'h0))
		else $error("transfer outstanding under grant");
	a_release_grant: assert property (@(posedge sys_clk) disable iff (reset)
		!clock_ctrl_bus_request |=> !clock_ctrl_bus_grant && cc_hold == 3'h0)
		else $error("grant or hold kept after request dropped");
	a_prio_default: assert property (@(posedge sys_clk)
		$fell(reset) |-> cc_prio == 3'h0)
		else $error("clock request priority not highest after reset");
endmodule

// [multilayer_ahb_crossbar_test.sv]
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("Error %s expected %h seen %h", w, e, g); end end
module multilayer_ahb_crossbar_test;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	xbar_pkg::ahb_req_s mst_req [xbar_pkg::N_MST];
	xbar_pkg::ahb_rsp_s mst_rsp [xbar_pkg::N_MST];
	xbar_pkg::ahb_req_s slv_req [xbar_pkg::N_SLV];
	xbar_pkg::ahb_rsp_s slv_rsp [xbar_pkg::N_SLV];
	xbar_pkg::arb_mode_e arb_mode [xbar_pkg::N_SLV];
	logic [2:0] park_mst [xbar_pkg::N_SLV];
	logic [2:0] mst_prio [xbar_pkg::N_MST];
	logic [1:0] waits [xbar_pkg::N_SLV];
	logic [31:0] wdata [xbar_pkg::N_SLV];
	logic clock_ctrl_bus_request = 1'b0;
	logic [2:0] cc_prio_in = 3'h0;
	logic cc_prio_load = 1'b0;
	logic clock_ctrl_bus_grant;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	multilayer_ahb_crossbar u_dut (.sys_clk(sys_clk), .reset(reset), .mst_req(mst_req),
		.mst_rsp(mst_rsp), .slv_req(slv_req), .slv_rsp(slv_rsp), .arb_mode(arb_mode),
		.park_mst(park_mst), .mst_prio(mst_prio), .cc_prio_in(cc_prio_in),
		.cc_prio_load(cc_prio_load),
		.clock_ctrl_bus_request(clock_ctrl_bus_request),
		.clock_ctrl_bus_grant(clock_ctrl_bus_grant));
	for (genvar i = 0; i < xbar_pkg::N_SLV; i++) begin : g_slv
		ahb_slave_model u_slv (.sys_clk(sys_clk), .reset(reset), .req(slv_req[i]),
			.rsp(slv_rsp[i]), .waits(waits[i]), .wdata(wdata[i]));
	end
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic xfer(input int m, input logic [31:0] a, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd, output logic rs, output int t);
		int k;
		@(posedge sys_clk);
		#1;
		mst_req[m].haddr = a;
		mst_req[m].hwrite = wr;
		mst_req[m].htrans = xbar_pkg::HTRANS_NONSEQ;
		t = cyc;
		@(posedge sys_clk);
		#1;
		mst_req[m].htrans = xbar_pkg::HTRANS_IDLE;
		mst_req[m].hwdata = wd;
		k = 0;
		while (mst_rsp[m].hready !== 1'b1 && k < 200) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (k == 200) errors++;
		rd = mst_rsp[m].hrdata;
		rs = mst_rsp[m].hresp;
		t = cyc - t;
	endtask
	task automatic t_reset();
		for (int i = 0; i < xbar_pkg::N_MST; i++) `CHK("idle ready", 1'b1, mst_rsp[i].hready)
		`CHK("idle grant", 1'b0, clock_ctrl_bus_grant)
		$display("reset test done");
	endtask
	task automatic t_paths();
		logic [31:0] rd, a;
		logic rs;
		int t;
		for (int m = 0; m < xbar_pkg::N_MST; m++) begin
			for (int s = 0; s < 4; s++) begin
				a = {s[1:0], 30'(m * 16 + 4)};
				xfer(m, a, 1'b1, 32'hC0DE_0000 + 32'(m), rd, rs, t);
				`CHK("write resp", (s == 3), rs)
				if (s < 3) `CHK("slave wdata", 32'hC0DE_0000 + 32'(m), wdata[s])
				xfer(m, a, 1'b0, 32'h0, rd, rs, t);
				if (s < 3) `CHK("read data", ~a, rd)
			end
		end
		$display("path test done");
	endtask
	task automatic t_conc();
		logic [31:0] r0, r1, r2;
		logic e0, e1, e2;
		int t0, t1, t2;
		fork
			xfer(0, 32'h8000_0008, 1'b0, 32'h0, r0, e0, t0);
			xfer(3, 32'h0000_000C, 1'b0, 32'h0, r1, e1, t1);
			xfer(5, 32'h4000_0010, 1'b0, 32'h0, r2, e2, t2);
		join
		`CHK("lat s2", 5, t0)
		`CHK("lat s0", 5, t1)
		`CHK("lat s1", 5, t2)
		`CHK("conc data", ~32'h4000_0010, r2)
		$display("concurrency test done");
	endtask
	task automatic race(input int a, input int b, output int first);
		logic [31:0] ra, rb;
		logic ea, eb;
		int ta, tb;
		fork
			xfer(a, 32'h0000_0010, 1'b0, 32'h0, ra, ea, ta);
			xfer(b, 32'h0000_0020, 1'b0, 32'h0, rb, eb, tb);
		join
		`CHK("stalled data", ~32'h0000_0020, rb)
		`CHK("serialised", 1'b1, ta != tb)
		first = (ta < tb) ? a : b;
	endtask
	task automatic t_arb();
		int w, v;
		logic [31:0] rd;
		logic rs;
		int t;
		waits[0] = 2'h2;
		race(3, 1, w);
		`CHK("fixed win", 1, w)
		arb_mode[0] = xbar_pkg::ARB_PROG;
		mst_prio[3] = 3'h0;
		mst_prio[1] = 3'h4;
		race(1, 3, w);
		`CHK("prog win", 3, w)
		arb_mode[0] = xbar_pkg::ARB_PARK;
		park_mst[0] = 3'h3;
		race(1, 3, w);
		`CHK("park win", 3, w)
		arb_mode[0] = xbar_pkg::ARB_RR;
		// last served is 1, so 3 is next in turn
		race(1, 3, w);
		`CHK("rr first", 3, w)
		// a lone transfer by 3 moves the turn past it
		xfer(3, 32'h0000_0030, 1'b0, 32'h0, rd, rs, t);
		race(1, 3, v);
		`CHK("rotation", 1'b1, w != v)
		waits[0] = 2'h0;
		$display("arbitration test done");
	endtask
	task automatic t_clock();
		logic [31:0] rd;
		logic rs;
		int t;
		@(posedge sys_clk);
		#1;
		clock_ctrl_bus_request = 1'b1;
		@(posedge sys_clk);
		#1;
		`CHK("early grant", 1'b0, clock_ctrl_bus_grant)
		@(posedge sys_clk);
		#1;
		`CHK("grant", 1'b1, clock_ctrl_bus_grant)
		fork
			xfer(2, 32'h4000_0040, 1'b0, 32'h0, rd, rs, t);
			begin
				repeat (12) @(posedge sys_clk);
				#1;
				`CHK("held stall", 1'b0, mst_rsp[2].hready)
				`CHK("no traffic", xbar_pkg::HTRANS_IDLE, slv_req[1].htrans)
				clock_ctrl_bus_request = 1'b0;
				@(posedge sys_clk);
				#1;
				`CHK("grant drop", 1'b0, clock_ctrl_bus_grant)
			end
		join
		`CHK("resumed read", ~32'h4000_0040, rd)
		$display("clock handshake test done");
	endtask
	task automatic t_prio();
		logic [31:0] rd;
		logic rs;
		int t;
		@(posedge sys_clk);
		#1;
		cc_prio_in = 3'h7;
		cc_prio_load = 1'b1;
		@(posedge sys_clk);
		#1;
		cc_prio_load = 1'b0;
		// request meets the waiting master at the same arbitration edge
		fork
			xfer(4, 32'h0000_0080, 1'b0, 32'h0, rd, rs, t);
			begin
				repeat (3) @(posedge sys_clk);
				#1;
				clock_ctrl_bus_request = 1'b1;
			end
		join
		`CHK("low prio request yields", 5, t)
		`CHK("read under request", ~32'h0000_0080, rd)
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK("late grant", 1'b1, clock_ctrl_bus_grant)
		clock_ctrl_bus_request = 1'b0;
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		`CHK("grant after reset", 1'b0, clock_ctrl_bus_grant)
		// after reset the request is highest again and takes the port first
		fork
			xfer(4, 32'h0000_0080, 1'b0, 32'h0, rd, rs, t);
			begin
				repeat (3) @(posedge sys_clk);
				#1;
				clock_ctrl_bus_request = 1'b1;
				repeat (4) @(posedge sys_clk);
				#1;
				`CHK("high prio request wins", 1'b0, mst_rsp[4].hready)
				clock_ctrl_bus_request = 1'b0;
			end
		join
		`CHK("resumed after reset", ~32'h0000_0080, rd)
		$display("priority test done");
	endtask
	initial begin
		#100000;
		errors++;
		close_out();
	end
	initial begin
		for (int i = 0; i < xbar_pkg::N_MST; i++) begin
			mst_req[i] = '0;
			mst_req[i].hsize = 3'h2;
			mst_prio[i] = 3'(i);
		end
		for (int i = 0; i < xbar_pkg::N_SLV; i++) begin
			arb_mode[i] = xbar_pkg::ARB_FIXED;
			park_mst[i] = 3'h7;
			waits[i] = 2'h0;
		end
		repeat (8) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		t_reset();
		t_paths();
		t_conc();
		t_arb();
		t_clock();
		t_prio();
		close_out();
	end
endmodule

// [xbar_pkg.sv]
package xbar_pkg;
	localparam int N_MST = 6;
	localparam int N_SLV = 3;
	localparam int SEL_MSB = 31;
	localparam int SEL_LSB = 30;
	localparam logic [1:0] SEL_NONE = 2'h3;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HBURST_SINGLE = 3'h0;
	localparam logic [2:0] CC_PRIO_RST = 3'h0;
	localparam logic [2:0] RR_LAST_RST = 3'h5;

	typedef enum logic [1:0] {
		ARB_FIXED = 2'h0,
		ARB_PROG = 2'h1,
		ARB_PARK = 2'h2,
		ARB_RR = 2'h3
	} arb_mode_e;

	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_WDAT = 4'h2,
		M_WAIT = 4'h4,
		M_ERR = 4'h8
	} mst_state_e;

	typedef enum logic [2:0] {
		S_IDLE = 3'h1,
		S_ADDR = 3'h2,
		S_DATA = 3'h4
	} slv_state_e;

	typedef struct packed {
		logic [31:0] haddr;
		logic hwrite;
		logic [2:0] hsize;
		logic [2:0] hburst;
		logic [3:0] hprot;
		logic [1:0] htrans;
		logic [31:0] hwdata;
	} ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hready;
		logic hresp;
	} ahb_rsp_s;
endpackage
